// ===== logic/motor_event_filter_config.sv
// Motor input detection configuration: tacho edges, output polarity, Z filter,
// D-to-Z blanking, sampling clock, encoder capture trigger, unused phase inputs.
// Assumes phase sense, tacho and comparator inputs are asynchronous pins.
`timescale 1ns/100ps
module motor_event_filter_config
    import motor_event_pkg::*;
#(
    parameter int WIN_WIDTH = 10
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire motor_event_pkg::reg_req_t reg_req_i,
    output logic [7:0] rdata_o,
    // Operating unit context
    input wire logic independent_phase_config_i,
    input wire logic sensor_mode_select_i,
    input wire logic motor_output_enable_i,
    input wire logic pwm_sample_i,
    input wire logic pwm_sample_mode_i,
    input wire logic rtc_tick_i,
    input wire logic timer_high_byte_read_i,
    // Pins
    input wire logic tacho_i,
    input wire logic d_cond_i,
    input wire logic z_cond_i,
    input wire logic [5:0] drive_i,
    output logic [5:0] drive_o,
    output logic [2:0] phase_sense_input_o,
    output logic [2:0] phase_sense_input_oe_o,
    // Events
    output logic speed_mode_o,
    output logic tacho_capture_o,
    output logic encoder_capture_o,
    output logic d_event_o,
    output logic z_event_o,
    output logic blanking_o
);

    polarity_reg_t polarity;
    filter_reg_t filter;
    sample_reg_t sample;
    win_state_t win_state;
    win_state_t next_win_state;
    logic [2:0] tacho_sync;
    logic [1:0] d_sync;
    logic [1:0] z_sync;
    logic [7:0] periph_cnt;
    logic periph_tick;
    logic [4:0] smp_cnt;
    logic smp_tick;
    logic [3:0] z_run;
    logic d_prev;
    logic d_edge;
    logic win_busy;
    logic [WIN_WIDTH-1:0] win_len;
    logic z_strobe;
    logic tacho_rise;
    logic tacho_fall;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            polarity <= RESET_POLARITY;
            filter <= RESET_FILTER;
            sample <= RESET_SAMPLE;
        end
        else if (reg_req_i.wr)
        begin
            case (reg_req_i.addr)
                ADDR_POLARITY: polarity <= reg_req_i.wdata;
                ADDR_FILTER: filter <= reg_req_i.wdata;
                // Reserved bits held at zero whatever software writes
                ADDR_SAMPLE: sample <= reg_req_i.wdata & SAMPLE_WRITE_MASK;
                default: ;
            endcase
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_o <= 8'h00;
        else if (reg_req_i.rd)
        begin
            case (reg_req_i.addr)
                ADDR_POLARITY: rdata_o <= polarity;
                ADDR_FILTER: rdata_o <= filter;
                ADDR_SAMPLE: rdata_o <= sample;
                default: rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tacho_sync <= 3'h0;
            d_sync <= 2'h0;
            z_sync <= 2'h0;
        end
        else
        begin
            tacho_sync <= {tacho_sync[1:0], tacho_i};
            d_sync <= {d_sync[0], d_cond_i};
            z_sync <= {z_sync[0], z_cond_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time base

    // Peripheral tick at 4 MHz; all windows count these
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            periph_cnt <= 8'h00;
        else if (periph_cnt == 8'(PERIPH_DIV - 1))
            periph_cnt <= 8'h00;
        else
            periph_cnt <= periph_cnt + 8'h01;
    end

    assign periph_tick = (periph_cnt == 8'(PERIPH_DIV - 1));

    // Sample clock period is base ticks shifted by select code
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            smp_cnt <= 5'h00;
        else if (periph_tick)
        begin
            if (smp_tick)
                smp_cnt <= 5'h00;
            else
                smp_cnt <= smp_cnt + 5'h01;
        end
    end

    assign smp_tick = periph_tick
        && (smp_cnt == 5'((SAMPLE_BASE_TICKS << sample.sample_clock_select) - 1));

    ////////////////////////////////////////////////////////////////////////
    // Tacho capture and mode

    assign tacho_rise = tacho_sync[1] && !tacho_sync[2];
    assign tacho_fall = !tacho_sync[1] && tacho_sync[2];

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            speed_mode_o <= 1'b0;
            tacho_capture_o <= 1'b0;
        end
        else
        begin
            speed_mode_o <= (polarity.tacho_edge_select != EDGE_NONE);
            case (polarity.tacho_edge_select)
                EDGE_RISE: tacho_capture_o <= tacho_rise;
                EDGE_FALL: tacho_capture_o <= tacho_fall;
                EDGE_BOTH: tacho_capture_o <= tacho_rise || tacho_fall;
                default: tacho_capture_o <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            encoder_capture_o <= 1'b0;
        else if (sample.encoder_capture_source)
            encoder_capture_o <= timer_high_byte_read_i;
        else
            encoder_capture_o <= rtc_tick_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output polarity and unused inputs

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            drive_o <= 6'h00;
        else if (independent_phase_config_i)
            drive_o <= drive_i;
        else
            drive_o <= drive_i ^ polarity.output_polarity;
    end

    // Grounding drives low; floating releases the pins
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            phase_sense_input_oe_o <= 3'h0;
        else if (!independent_phase_config_i && polarity.tacho_edge_select == EDGE_NONE
            && !sensor_mode_select_i)
            phase_sense_input_oe_o <= {3{!sample.unused_input_float}};
        else
            phase_sense_input_oe_o <= 3'h0;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            phase_sense_input_o <= 3'h0;
        else
            phase_sense_input_o <= 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // D event and blanking window

    // D uses the sample clock only, never the PWM delay
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            d_prev <= 1'b0;
        else if (smp_tick)
            d_prev <= d_sync[1];
    end

    assign d_edge = smp_tick && d_sync[1] && !d_prev;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            d_event_o <= 1'b0;
        else
            d_event_o <= d_edge;
    end

    always_comb
    begin
        if (filter.d_to_z_window_length[3])
            win_len = WIN_WIDTH'((WIN_LONG_BASE_US + WIN_LONG_STEP_US
                * int'(filter.d_to_z_window_length[2:0])) * TICKS_PER_US);
        else
            win_len = WIN_WIDTH'(WIN_SHORT_STEP_US
                * (int'(filter.d_to_z_window_length[2:0]) + 1) * TICKS_PER_US);
    end

    window_timer #(
        .WIDTH(WIN_WIDTH)
    ) u_window_timer (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(d_edge && !sensor_mode_select_i),
        .length_i(win_len),
        .tick_i(periph_tick),
        .busy_o(win_busy)
    );

    always_comb
    begin
        next_win_state = win_state;
        case (win_state)
            WIN_IDLE: if (d_edge && !sensor_mode_select_i) next_win_state = WIN_BLANK;
            WIN_BLANK: if (!win_busy) next_win_state = WIN_OPEN;
            WIN_OPEN: if (d_edge && !sensor_mode_select_i) next_win_state = WIN_BLANK;
            default: next_win_state = WIN_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            win_state <= WIN_IDLE;
        else
            win_state <= next_win_state;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            blanking_o <= 1'b0;
        else
            blanking_o <= (next_win_state == WIN_BLANK);
    end

    ////////////////////////////////////////////////////////////////////////
    // Z filter

    // With outputs off, sampling runs only if software enables it
    assign z_strobe = (pwm_sample_mode_i ? pwm_sample_i : smp_tick)
        && (motor_output_enable_i || sample.z_sampling_enable)
        && win_state != WIN_BLANK && !(d_edge && !sensor_mode_select_i);

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            z_run <= 4'h0;
        else if (d_edge)
            z_run <= 4'h0;
        else if (z_strobe)
        begin
            if (!z_sync[1])
                z_run <= 4'h0;
            else if (z_run < filter.z_sample_count)
                z_run <= z_run + 4'h1;
        end
    end

    // Event fires on the first sample after the run completes and on every later sample while Z stays high
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            z_event_o <= 1'b0;
        else
            z_event_o <= z_strobe && z_sync[1] && !d_edge
                && z_run >= filter.z_sample_count;
    end

endmodule

// ===== logic/motor_event_pkg.sv
// Constants and carrier types for the motor event filter and configuration block.
// Assumes a 100 MHz core clock and a 4 MHz nominal peripheral time base.
package motor_event_pkg;

    // Register offsets (page 1 numbering, low address bits only)
    localparam logic [2:0] ADDR_POLARITY = 3'h4;
    localparam logic [2:0] ADDR_FILTER = 3'h5;
    localparam logic [2:0] ADDR_SAMPLE = 3'h6;

    // Reset values
    localparam logic [7:0] RESET_POLARITY = 8'h00;
    localparam logic [7:0] RESET_FILTER = 8'h0f;
    localparam logic [7:0] RESET_SAMPLE = 8'h00;
    localparam logic [7:0] SAMPLE_WRITE_MASK = 8'h8f;

    // Timing
    localparam int CLOCK_HZ = 100000000;
    localparam int PERIPH_HZ = 4000000;
    localparam int PERIPH_DIV = CLOCK_HZ / PERIPH_HZ;
    // Periph ticks per microsecond
    localparam int TICKS_PER_US = PERIPH_HZ / 1000000;
    localparam int WIN_SHORT_STEP_US = 5;
    localparam int WIN_LONG_BASE_US = 60;
    localparam int WIN_LONG_STEP_US = 20;
    // Sample clock: 1 MHz for code 00, halving per step
    localparam int SAMPLE_BASE_TICKS = PERIPH_HZ / 1000000;

    // Tacho edge codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef struct packed {
        logic [1:0] tacho_edge_select;
        logic [5:0] output_polarity;
    } polarity_reg_t;

    typedef struct packed {
        logic [3:0] z_sample_count;
        logic [3:0] d_to_z_window_length;
    } filter_reg_t;

    typedef struct packed {
        logic z_sampling_enable;
        logic [2:0] reserved;
        logic [1:0] sample_clock_select;
        logic encoder_capture_source;
        logic unused_input_float;
    } sample_reg_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [2:0]
    {
        WIN_IDLE = 3'b001,
        WIN_BLANK = 3'b010,
        WIN_OPEN = 3'b100
    } win_state_t;

endpackage

// ===== logic/window_timer.sv
// Blanking window down-counter, loaded with a tick count and stepped by a tick.
// Assumes load and tick come from logic on the same clock.
`timescale 1ns/100ps
module window_timer
#(
    parameter int WIDTH = 10
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic load_i,
    input wire logic [WIDTH-1:0] length_i,
    input wire logic tick_i,
    // Status
    output logic busy_o
);

    logic [WIDTH-1:0] count;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count <= '0;
        else if (load_i)
            count <= length_i;
        else if (tick_i && count != '0)
            count <= count - WIDTH'(1);
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            busy_o <= 1'b0;
        else if (load_i)
            busy_o <= (length_i != '0);
        else if (tick_i && count <= WIDTH'(1))
            busy_o <= 1'b0;
    end

endmodule

// ===== bench/motor_event_filter_config_props.sv
// Checker for the motor event block: register mirror and port relations.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/100ps
module motor_event_filter_config_props
    import motor_event_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire motor_event_pkg::reg_req_t reg_req_i,
    input wire logic [7:0] rdata_o,
    // Context and pins
    input wire logic independent_phase_config_i,
    input wire logic sensor_mode_select_i,
    input wire logic rtc_tick_i,
    input wire logic timer_high_byte_read_i,
    input wire logic [5:0] drive_i,
    input wire logic [5:0] drive_o,
    input wire logic [2:0] phase_sense_input_o,
    input wire logic [2:0] phase_sense_input_oe_o,
    // Events
    input wire logic speed_mode_o,
    input wire logic tacho_capture_o,
    input wire logic encoder_capture_o,
    input wire logic z_event_o,
    input wire logic blanking_o
);
    logic [7:0] pol;
    logic [7:0] filt;
    logic [7:0] samp;
    logic [7:0] rd_view;
    logic ground_ok;
    int blank_cnt;
    int win_clk;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pol <= 8'h00;
            filt <= 8'h0f;
            samp <= 8'h00;
        end
        else if (reg_req_i.wr)
        begin
            case (reg_req_i.addr)
                ADDR_POLARITY: pol <= reg_req_i.wdata;
                ADDR_FILTER: filt <= reg_req_i.wdata;
                ADDR_SAMPLE: samp <= reg_req_i.wdata & 8'h8f;
                default: ;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            blank_cnt <= 0;
        else
            blank_cnt <= blanking_o ? blank_cnt + 1 : 0;
    end
    always_comb
    begin
        case (reg_req_i.addr)
            ADDR_POLARITY: rd_view = pol;
            ADDR_FILTER: rd_view = filt;
            ADDR_SAMPLE: rd_view = samp;
            default: rd_view = 8'h00;
        endcase
        ground_ok = !independent_phase_config_i && pol[7:6] == 2'h0;
        ground_ok = ground_ok && !sensor_mode_select_i && !samp[0];
        // Window in clocks: 100 clocks per microsecond; tick phase gives slack
        win_clk = filt[3] ? (60 + 20 * (int'(filt[2:0]))) * 100 : 5 * (int'(filt[2:0]) + 1) * 100;
    end
    ////////////////////////////////////////////////////////////////////////////////
    AST_READ_DATA: assert property (reg_req_i.rd |=> rdata_o == $past(rd_view))
        else $error("read data differs from register contents");
    AST_READ_IDLE: assert property (!reg_req_i.rd |=> rdata_o == 8'h00)
        else $error("read data outside a read answer");
    AST_DRIVE_LEVEL: assert property ($past(reset_n_i) |-> drive_o == ($past(drive_i) ^
        ($past(independent_phase_config_i) ? 6'h00 : $past(pol[5:0]))))
        else $error("channel level differs from polarity setting");
    AST_SPEED_MODE: assert property ($stable(pol) |-> speed_mode_o == (pol[7:6] != 2'h0))
        else $error("speed mode differs from edge code");
    AST_TACHO_MODE: assert property (tacho_capture_o |-> $past(pol[7:6]) != 2'h0)
        else $error("tacho capture with edge code zero");
    AST_ENC_SOURCE: assert property ($past(reset_n_i) |-> encoder_capture_o == ($past(samp[1])
        ? $past(timer_high_byte_read_i) : $past(rtc_tick_i)))
        else $error("encoder capture from wrong source");
    AST_SENSE_GROUND: assert property ($past(reset_n_i) |->
        phase_sense_input_oe_o == {3{$past(ground_ok)}} && phase_sense_input_o == 3'h0)
        else $error("unused input grounding wrong");
    AST_NO_WINDOW_SENSOR: assert property ($rose(blanking_o) |-> !$past(sensor_mode_select_i))
        else $error("blanking window in sensor mode");
    AST_Z_BLANKED: assert property (blanking_o && $past(blanking_o) |-> !z_event_o)
        else $error("Z event inside blanking window");
    AST_WINDOW_LEN: assert property ($fell(blanking_o) |->
        blank_cnt + 40 >= win_clk && blank_cnt <= win_clk + 40)
        else $error("blanking window length wrong");
endmodule

bind motor_event_filter_config motor_event_filter_config_props u_props (.ref_clk_i, .reset_n_i,
    .reg_req_i, .rdata_o, .independent_phase_config_i, .sensor_mode_select_i, .rtc_tick_i,
    .timer_high_byte_read_i, .drive_i, .drive_o, .phase_sense_input_o, .phase_sense_input_oe_o,
    .speed_mode_o, .tacho_capture_o, .encoder_capture_o, .z_event_o, .blanking_o);

// ===== bench/rotor_sense_model.sv
// Rotor sense model: turns requested tacho, D and Z levels into pin levels.
// Assumes the bench sets levels just after a rising edge.
`timescale 1ns/100ps
module rotor_sense_model
(
    // Clock and requested levels: tacho, D, Z
    input wire logic ref_clk_i,
    input wire logic [2:0] level_i,
    // Lines grounded by the device
    input wire logic [2:0] sense_oe_i,
    // Pins
    output logic tacho_o,
    output logic d_cond_o,
    output logic z_cond_o,
    output logic [2:0] sense_line_o
);
    initial {tacho_o, d_cond_o, z_cond_o} = 3'h0;
    // Comparators settle a little after the edge, never on the sampling instant
    always @(posedge ref_clk_i)
        {tacho_o, d_cond_o, z_cond_o} <= #2 level_i;
    // A floating line drifts up through the comparator bias, so it reads high
    assign sense_line_o = ~sense_oe_i;
endmodule

// ===== bench/motor_event_filter_config_tb.sv
// Testbench: register tasks and pin stimulus through the rotor model, self-checking.
// Assumes the design answers reads one cycle after the strobe.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module motor_event_filter_config_tb;
    import motor_event_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    reg_req_t reg_req_i = '0;
    logic indep = 1'b0, sensor = 1'b1, out_en = 1'b1, pwm_s = 1'b0, pwm_m = 1'b1;
    logic rtc = 1'b0, thr = 1'b0;
    logic [2:0] lvl = 3'h0;
    logic [5:0] drv = 6'h00;
    logic [7:0] rdata_o;
    logic [5:0] drive_o;
    logic [2:0] ps_oe, sense;
    logic tacho, d_c, z_c, spd, tcap, ecap, dev, zev, blank;
    int num_errors = 0, samples_checked = 0;
    int n, k, zcnt, tcnt, ecnt;
    int zc[3] = '{0, 2, 15};
    int wc[4] = '{0, 7, 8, 15};
    always #5 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i)
    begin
        zcnt += (zev === 1'b1);
        tcnt += (tcap === 1'b1);
        ecnt += (ecap === 1'b1);
    end
    rotor_sense_model u_rotor_sense_model (.ref_clk_i, .level_i(lvl), .sense_oe_i(ps_oe),
        .tacho_o(tacho), .d_cond_o(d_c), .z_cond_o(z_c), .sense_line_o(sense));
    motor_event_filter_config u_motor_event_filter_config (.ref_clk_i, .reset_n_i, .reg_req_i,
        .rdata_o, .independent_phase_config_i(indep), .sensor_mode_select_i(sensor),
        .motor_output_enable_i(out_en), .pwm_sample_i(pwm_s), .pwm_sample_mode_i(pwm_m),
        .rtc_tick_i(rtc), .timer_high_byte_read_i(thr), .tacho_i(tacho), .d_cond_i(d_c),
        .z_cond_i(z_c), .drive_i(drv), .drive_o, .phase_sense_input_o(),
        .phase_sense_input_oe_o(ps_oe), .speed_mode_o(spd), .tacho_capture_o(tcap),
        .encoder_capture_o(ecap), .d_event_o(dev), .z_event_o(zev), .blanking_o(blank));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_req_i <= {a, d, 2'b10};
        cyc(1);
        reg_req_i <= '0;
        cyc(1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        reg_req_i <= {a, 8'h00, 2'b01};
        cyc(1);
        reg_req_i <= '0;
        #1 `CHK("rdata", e, rdata_o)
        cyc(1);
    endtask
    task automatic strobe(input int c);
        repeat (c)
        begin
            pwm_s <= 1'b1;
            cyc(1);
            pwm_s <= 1'b0;
            cyc(3);
        end
    endtask
    // Bounded wait for a Z (0) or D (1) event; a lost event ends at 2000
    task automatic wait_ev(input int w, output int c);
        c = 0;
        do
        begin
            cyc(1);
            c++;
        end while ((w ? dev : zev) !== 1'b1 && c < 2000);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #600000;
        num_errors++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(12);
        reset_n_i <= 1'b1;
        cyc(1);
        rd(ADDR_POLARITY, 8'h00);
        rd(ADDR_FILTER, 8'h0f);
        rd(ADDR_SAMPLE, 8'h00);
        rd(3'h7, 8'h00);
        wr(ADDR_SAMPLE, 8'h8f);
        rd(ADDR_SAMPLE, 8'h8f);
        drv <= 6'h15;
        wr(ADDR_POLARITY, 8'h3f);
        cyc(2);
        `CHK("drive", 6'h2a, drive_o)
        indep <= 1'b1;
        cyc(2);
        `CHK("drive", 6'h15, drive_o)
        indep <= 1'b0;
        sensor <= 1'b0;
        wr(ADDR_POLARITY, 8'h00);
        wr(ADDR_SAMPLE, 8'h00);
        cyc(2);
        `CHK("sense_oe", 3'h7, ps_oe)
        `CHK("sense_line", 3'h0, sense)
        wr(ADDR_SAMPLE, 8'h01);
        cyc(2);
        `CHK("sense_oe", 3'h0, ps_oe)
        `CHK("sense_line", 3'h7, sense)
        $display("test registers and pins done");
        for (n = 0; n < 2; n++)
        begin
            wr(ADDR_SAMPLE, {6'h00, n[0], 1'b0});
            ecnt = 0;
            rtc <= 1'b1;
            cyc(1);
            rtc <= 1'b0;
            cyc(3);
            `CHK("enc_rtc", int'(!n[0]), ecnt)
            thr <= 1'b1;
            cyc(1);
            thr <= 1'b0;
            cyc(3);
            `CHK("enc_all", 1, ecnt)
        end
        for (n = 1; n < 4; n++)
        begin
            wr(ADDR_POLARITY, {n[1:0], 6'h00});
            cyc(1);
            `CHK("speed", 1'b1, spd)
            tcnt = 0;
            lvl[2] <= 1'b1;
            cyc(8);
            `CHK("tacho_rise", int'(n[0]), tcnt)
            lvl[2] <= 1'b0;
            cyc(8);
            `CHK("tacho_both", int'(n[0]) + int'(n[1]), tcnt)
        end
        wr(ADDR_POLARITY, 8'h00);
        cyc(1);
        `CHK("speed", 1'b0, spd)
        $display("test capture done");
        sensor <= 1'b1;
        for (n = 0; n < 3; n++)
        begin
            wr(ADDR_FILTER, {zc[n][3:0], 4'h0});
            lvl[0] <= 1'b0;
            cyc(4);
            strobe(1);
            lvl[0] <= 1'b1;
            cyc(4);
            zcnt = 0;
            strobe(zc[n]);
            `CHK("z_early", 0, zcnt)
            strobe(1);
            `CHK("z_event", 1, zcnt)
        end
        wr(ADDR_FILTER, 8'h00);
        out_en <= 1'b0;
        cyc(1);
        zcnt = 0;
        strobe(1);
        `CHK("z_gated", 0, zcnt)
        wr(ADDR_SAMPLE, 8'h80);
        strobe(1);
        `CHK("z_enabled", 1, zcnt)
        out_en <= 1'b1;
        pwm_m <= 1'b0;
        for (n = 0; n < 4; n++)
        begin
            wr(ADDR_SAMPLE, {4'h8, n[1:0], 2'h0});
            repeat (3) wait_ev(0, k);
            `CHK("z_period", 100 << n, k)
        end
        $display("test Z filter done");
        pwm_m <= 1'b1;
        sensor <= 1'b0;
        wr(ADDR_SAMPLE, 8'h80);
        for (n = 0; n < 5; n++)
        begin
            sensor <= (n == 4);
            wr(ADDR_FILTER, {4'h0, wc[n % 4][3:0]});
            lvl[1] <= 1'b1;
            wait_ev(1, k);
            `CHK("d_event", 1'b1, dev)
            zcnt = 0;
            strobe(1);
            `CHK("z_blanked", int'(n == 4), zcnt)
            k = 0;
            while (blank === 1'b1 && k < 25000)
            begin
                cyc(1);
                k++;
            end
            strobe(1);
            `CHK("z_after", int'(n == 4) + 1, zcnt)
            lvl[1] <= 1'b0;
            cyc(250);
        end
        $display("test blanking done");
        summarize();
    end
endmodule
